// ===== verilog/acpr_params.svh
// Constants for the conversion, power-down and reset control block
`ifndef ACPR_PARAMS_SVH
`define ACPR_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ACPR_CLK_PERIOD_NS   10
`define ACPR_CONV_SLOPE_NS   550
`define ACPR_CONV_OFFSET_NS  40
`define ACPR_INIT_WAIT_MS    10
`define ACPR_RST_TIMER_NS    1000
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ACPR_SPAN_W          6
`define ACPR_SPAN_RESET      6'h3F
`define ACPR_SPAN_OFF        3'h0
`endif

// ===== verilog/acpr_pkg.sv
// Types for the conversion, power-down and reset control block
package acpr_pkg;
   typedef enum logic [2:0] {
      ST_INIT  = 3'b000,
      ST_NAP   = 3'b001,
      ST_CONV  = 3'b010,
      ST_PDN   = 3'b011,
      ST_GRST  = 3'b100
   } acpr_state_t;

   // Span word carried from the serial side, two 3-bit codes
   typedef struct packed {
      logic [2:0] ch1;
      logic [2:0] ch0;
   } acpr_span_t;

   // Status flags that leave the block together
   typedef struct packed {
      logic busy;
      logic nap;
      logic powerDown;
      logic windowOpen;
      logic ready;
   } acpr_status_t;
endpackage : acpr_pkg

// ===== verilog/acpr_sync_edge.sv
// Two-flop synchroniser with rising-edge detect behind it
`timescale 1ns/10ps
module acpr_sync_edge (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // Pin in, synchronised level and edge out
   input  wire logic pinIn,
   output logic      level,
   output logic      rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } acpr_sync_state_t;

   acpr_sync_state_t st_q;
   acpr_sync_state_t st_d;

   // First flop is read only by the second
   always_comb begin
      st_d    = st_q;
      st_d.s1 = pinIn;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.s2;
   assign rise  = st_q.s2 & ~st_q.s3;
endmodule : acpr_sync_edge

// ===== verilog/acpr_control.sv
// Conversion sequencing, power-down and global reset control
`timescale 1ns/10ps
`include "acpr_params.svh"

// Notes on behaviour
// RQ1: Trigger rising edge samples both channels, starts conversion
// RQ2: Started conversion always completes unless reset
// RQ3: Busy high from start until conversion done
// RQ4: Host lowers trigger 40-60ns later or after busy
// RQ5: Host keeps trigger low 410ns after late low
// RQ6: Conversion time at most 550 times N minus 40ns
// RQ7: Host keeps data lines quiet before trigger edge
// RQ8: Power-down pin high ignores all conversion requests
// RQ9: Power-down during conversion waits for its end
// RQ10: Host waits 10ms after power-down exit
// RQ11: Host waits 200ms with internal reference buffer
// RQ12: Second power-down rise without conversion: global reset
// RQ13: Global reset ends by internal timer
// RQ14: Global reset clears outputs, span back to 7
// RQ15: Global reset halts running conversion at once
// RQ16: Global reset leaves power-down behaviour unchanged
// RQ17: Supply-low reset at power-up and below 2V
// RQ18: Host waits 10ms after supply reset
// RQ19: Nap after each conversion, wake on trigger
// RQ20: Select pin picks CMOS or LVDS signalling
// RQ21: CMOS mode uses one or two output lanes
// RQ22: Data window opens after init and busy fall
// RQ23: Six-bit span register resets to all ones
// RQ24: Span code 000 disables channel, shortens conversion
// RQ25: Host must not trigger while busy is high
module acpr_control
   import acpr_pkg::*;
#(
   parameter int INIT_CYCLES = (`ACPR_INIT_WAIT_MS * 1000000) / `ACPR_CLK_PERIOD_NS,
   parameter int RST_CYCLES  = (`ACPR_RST_TIMER_NS + `ACPR_CLK_PERIOD_NS - 1)
                               / `ACPR_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic   clk_sys,
   input  wire logic   reset,
   // Pins from the host
   input  wire logic   conversion_trigger,
   input  wire logic   power_down_pin,
   input  wire logic   supply_low,
   input  wire logic   lvds_select,
   input  wire logic   two_lane_select,
   // Span word from the serial side
   input  wire logic   spanWrite,
   input  wire acpr_span_t spanIn,
   // Status and control outputs
   output logic        busy,
   output logic        holdSample,
   output logic        napMode,
   output logic        powerDownMode,
   output logic        windowOpen,
   output logic        initDone,
   output logic        clearOutputs,
   output acpr_span_t  spanCfg,
   output logic        lvdsMode,
   output logic        laneOneEnable,
   output logic [1:0]  chanCount
);
   // ----------------------------------------
   // Derived counts
   // ----------------------------------------
   // Longest time rounds down to whole cycles
   localparam int CONV1_CYCLES = (`ACPR_CONV_SLOPE_NS - `ACPR_CONV_OFFSET_NS)
                                 / `ACPR_CLK_PERIOD_NS;
   localparam int CONV2_CYCLES = (2 * `ACPR_CONV_SLOPE_NS - `ACPR_CONV_OFFSET_NS)
                                 / `ACPR_CLK_PERIOD_NS;
   localparam int CW = 24;

   typedef struct packed {
      acpr_state_t st;
      logic [CW-1:0] cnt;
      logic        pdArmed;
      logic        busy;
      logic        hold;
      logic        window;
      logic        ready;
      logic        clr;
      acpr_span_t  span;
      logic        lvds;
      logic        lane1;
      logic        nap;
      logic        pdn;
      logic [1:0]  nch;
   } acpr_ctrl_t;

   acpr_ctrl_t s_q;
   acpr_ctrl_t s_d;

   logic trigLvl;
   logic trigRise;
   logic pdLvl;
   logic pdRise;
   logic supLvl;
   logic supRise;
   logic lvdsLvl;
   logic laneLvl;
   logic [1:0] enCount;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   acpr_sync_edge u_trig (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   (conversion_trigger),
      .level   (trigLvl),
      .rise    (trigRise)
   );

   acpr_sync_edge u_pd (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   (power_down_pin),
      .level   (pdLvl),
      .rise    (pdRise)
   );

   acpr_sync_edge u_sup (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   (supply_low),
      .level   (supLvl),
      .rise    (supRise)
   );

   // Interface straps are pins too; only their level is used
   acpr_sync_edge u_lvds (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   (lvds_select),
      .level   (lvdsLvl),
      .rise    ()
   );

   acpr_sync_edge u_lane (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   (two_lane_select),
      .level   (laneLvl),
      .rise    ()
   );

   // Enabled channel count from span codes
   always_comb begin
      enCount = 2'(s_q.span.ch0 != `ACPR_SPAN_OFF)
              + 2'(s_q.span.ch1 != `ACPR_SPAN_OFF); // [RQ24]
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.clr    = 1'b0;
      s_d.window = 1'b0;
      s_d.lvds   = lvdsLvl;                           // [RQ20]
      s_d.lane1  = ~lvdsLvl & laneLvl;                // [RQ21]
      if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
      // Span changes take effect at once, but never mid-conversion or in reset
      if (spanWrite && s_q.st != ST_CONV && s_q.st != ST_GRST) begin
         s_d.span = spanIn;
      end
      if (supLvl || supRise) begin
         // Supply-low holds the core in reset until it recovers
         s_d.st    = ST_INIT;                          // [RQ17]
         s_d.cnt   = CW'(INIT_CYCLES);
         s_d.busy  = 1'b0;
         s_d.hold  = 1'b0;
         s_d.ready = 1'b0;
         s_d.clr   = 1'b1;
         s_d.span  = `ACPR_SPAN_RESET;                 // [RQ23]
         s_d.pdArmed = 1'b0;
      end else if (pdRise && s_q.pdArmed) begin
         // Second power-down rise with no conversion between
         s_d.st    = ST_GRST;                          // [RQ12]
         s_d.cnt   = CW'(RST_CYCLES);
         s_d.busy  = 1'b0;                             // [RQ15]
         s_d.hold  = 1'b0;
         s_d.ready = 1'b0;
         s_d.clr   = 1'b1;                             // [RQ14]
         s_d.span  = `ACPR_SPAN_RESET;                 // [RQ14]
         s_d.pdArmed = 1'b0;
      end else begin
         if (pdRise) begin
            s_d.pdArmed = 1'b1;
         end
         case (s_q.st)
            ST_INIT: begin
               if (s_q.cnt == '0) begin
                  s_d.st     = pdLvl ? ST_PDN : ST_NAP;
                  s_d.ready  = 1'b1;
                  s_d.window = 1'b1;                   // [RQ22]
               end
            end
            ST_NAP: begin
               if (pdLvl) begin
                  s_d.st = ST_PDN;                     // [RQ8]
               end else if (trigRise && enCount != 2'h0) begin
                  s_d.st      = ST_CONV;               // [RQ1] [RQ19]
                  s_d.busy    = 1'b1;                  // [RQ3]
                  s_d.hold    = 1'b1;
                  s_d.nch     = enCount;
                  s_d.pdArmed = 1'b0;
                  s_d.cnt     = (enCount == 2'h2) ? CW'(CONV2_CYCLES - 1)
                                                  : CW'(CONV1_CYCLES - 1); // [RQ6]
               end
            end
            ST_CONV: begin
               // Triggers are ignored; power-down waits for the end
               if (s_q.cnt == '0) begin                // [RQ2] [RQ9]
                  s_d.busy   = 1'b0;                   // [RQ3]
                  s_d.hold   = 1'b0;
                  s_d.window = 1'b1;                   // [RQ22]
                  s_d.st     = pdLvl ? ST_PDN : ST_NAP; // [RQ19]
               end
            end
            ST_PDN: begin
               if (!pdLvl) begin
                  s_d.st = ST_NAP;                     // [RQ8] [RQ16]
               end
            end
            ST_GRST: begin
               // Timer ends reset; power-down pin still rules after
               if (s_q.cnt == '0) begin                // [RQ13]
                  s_d.st    = ST_INIT;
                  s_d.cnt   = CW'(INIT_CYCLES);
               end
            end
            default: begin
               s_d.st = ST_INIT;
            end
         endcase
      end
      // Mode flags are registered so the outputs leave straight from flops
      s_d.nap = (s_d.st == ST_NAP);
      s_d.pdn = (s_d.st == ST_PDN);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q       <= '0;
         s_q.st    <= ST_INIT;
         s_q.cnt   <= CW'(INIT_CYCLES);
         s_q.span  <= `ACPR_SPAN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from flops
   assign busy          = s_q.busy;
   assign holdSample    = s_q.hold;
   assign napMode       = s_q.nap;
   assign powerDownMode = s_q.pdn;
   assign windowOpen    = s_q.window;
   assign initDone      = s_q.ready;
   assign clearOutputs  = s_q.clr;
   assign spanCfg       = s_q.span;
   assign lvdsMode      = s_q.lvds;
   assign laneOneEnable = s_q.lane1;
   assign chanCount     = s_q.nch;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_busy_start: assert property (s_q.st == ST_NAP && !pdLvl && trigRise && enCount != 0
      && !supLvl && !supRise && !(pdRise && s_q.pdArmed) |=> busy) // [RQ1]
      else $error("busy not raised on trigger");
   a_busy_hold: assert property ($rose(busy) |=> busy [*8]) // [RQ3]
      else $error("busy dropped early");
   a_conv_len: assert property ($rose(busy) && chanCount == 2'h1 |-> ##[1:51] !busy) // [RQ6]
      else $error("single channel conversion too long");
   a_conv_len2: assert property ($rose(busy) && chanCount == 2'h2 |-> ##[1:106] !busy) // [RQ6]
      else $error("two channel conversion too long");
   a_pd_ignore: assert property (powerDownMode && pdLvl |=> !$rose(busy)) // [RQ8]
      else $error("conversion started in power-down");
   a_pd_waits: assert property (busy && s_q.st == ST_CONV && s_q.cnt != '0 && $rose(pdLvl)
      && !supLvl && !supRise && !s_q.pdArmed |=> busy) // [RQ9]
      else $error("power-down cut conversion");
   a_grst_span: assert property (s_q.st == ST_GRST |-> spanCfg == `ACPR_SPAN_RESET
      && !busy) // [RQ14]
      else $error("global reset left span or busy");
   a_grst_end: assert property ($rose(s_q.st == ST_GRST) |-> ##[1:101] s_q.st == ST_INIT) // [RQ13]
      else $error("global reset timer did not end");
   a_window_fall: assert property ($fell(busy) && s_q.st != ST_GRST && s_q.st != ST_INIT
      |-> windowOpen) // [RQ22]
      else $error("window missing at busy fall");
   a_lane_cmos: assert property (lvdsMode |-> !laneOneEnable) // [RQ21]
      else $error("second lane in LVDS mode");

   c_conv: cover property ($rose(busy) ##[1:110] $fell(busy));
   c_grst: cover property ($rose(s_q.st == ST_GRST));
   c_pdn: cover property ($rose(powerDownMode));
   c_one_ch: cover property ($rose(busy) && chanCount == 2'h1);
   c_lvds: cover property ($rose(lvdsMode));
endmodule : acpr_control

// ===== tb/acpr_host_model.sv
// Host model driving the trigger and power-down pins
`timescale 1ns/10ps
module acpr_host_model #(
   parameter int WAIT_CYCLES = 50
) (
   // Clock and device status
   input  wire logic clk_sys,
   input  wire logic busy,
   // Pins to the device
   output logic      conversion_trigger,
   output logic      power_down_pin
);
   // ---------------------------
   // Pin sequences
   // ---------------------------
   initial begin
      conversion_trigger = 1'b0;
      power_down_pin = 1'b0;
   end

   // A forced pulse skips the idle wait, to probe refusal
   task automatic pulseTrigger(input bit forced);
      int n;
      n = 0;
      while (!forced && busy !== 1'b0 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (41) @(posedge clk_sys); // Low time sets acquisition
      conversion_trigger <= 1'b1;
      repeat (5) @(posedge clk_sys); // Back low after 50 ns
      conversion_trigger <= 1'b0;
   endtask : pulseTrigger

   // Two rises with no conversion between reset the device
   task automatic setPowerDown(input logic level);
      @(posedge clk_sys);
      power_down_pin <= level;
      if (!level) repeat (WAIT_CYCLES) @(posedge clk_sys); // Settle wait
   endtask : setPowerDown
endmodule : acpr_host_model

// ===== tb/testbench.sv
// Self-checking bench for the conversion and reset control block
`timescale 1ns/10ps
module testbench;
   import acpr_pkg::*;
   // ---------------------------
   // Signals and monitors
   // ---------------------------
   localparam int INIT_C = 50;
   localparam int RST_C  = 10;
   logic       clk_sys, reset, trig, pd, supplyLow, lvdsSel, twoLane, spanWrite;
   logic       busy, holdSample, napMode, powerDownMode, windowOpen, initDone, clearOutputs;
   logic       lvdsMode, laneOneEnable;
   logic [1:0] chanCount;
   acpr_span_t spanIn, spanCfg;
   int         failures = 0, comparisons = 0, runLen = 0, busyLen = 0;
   int         convCount = 0, clrCount = 0, n, c;
   logic       busyPrev = 1'b0;

   acpr_control #(
      .INIT_CYCLES (INIT_C),
      .RST_CYCLES  (RST_C)
   ) acpr_control_i (
      .clk_sys            (clk_sys),
      .reset              (reset),
      .conversion_trigger (trig),
      .power_down_pin     (pd),
      .supply_low         (supplyLow),
      .lvds_select        (lvdsSel),
      .two_lane_select    (twoLane),
      .spanWrite          (spanWrite),
      .spanIn             (spanIn),
      .busy               (busy),
      .holdSample         (holdSample),
      .napMode            (napMode),
      .powerDownMode      (powerDownMode),
      .windowOpen         (windowOpen),
      .initDone           (initDone),
      .clearOutputs       (clearOutputs),
      .spanCfg            (spanCfg),
      .lvdsMode           (lvdsMode),
      .laneOneEnable      (laneOneEnable),
      .chanCount          (chanCount)
   );
   acpr_host_model #(
      .WAIT_CYCLES (INIT_C)
   ) acpr_host_model_i (
      .clk_sys            (clk_sys),
      .busy               (busy),
      .conversion_trigger (trig),
      .power_down_pin     (pd)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Busy length, conversion starts and clear pulses, seen from outside
   always @(posedge clk_sys) begin
      busyPrev <= busy;
      if (busy === 1'b1) runLen <= runLen + 1;
      else if (runLen != 0) begin
         busyLen <= runLen;
         runLen <= 0;
      end
      if (busy === 1'b1 && busyPrev !== 1'b1) convCount <= convCount + 1;
      if (clearOutputs === 1'b1) clrCount <= clrCount + 1;
      if (reset === 1'b0) check("holdSample", {7'h0, holdSample}, {7'h0, busy});
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   // Full conversion: window pulse at busy fall, then length
   task automatic runConv(input int expLen, input logic expNap);
      int k;
      acpr_host_model_i.pulseTrigger(1'b0);
      k = 0;
      while (windowOpen !== 1'b1 && k < 300) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      check("windowOpen", {7'h0, windowOpen}, 8'h01);
      check("napMode", {7'h0, napMode}, {7'h0, expNap});
      @(posedge clk_sys);
      #1;
      check("busyLen", 8'(busyLen), 8'(expLen));
   endtask : runConv

   task automatic writeSpan(input logic [5:0] v);
      @(posedge clk_sys);
      spanIn <= acpr_span_t'(v);
      spanWrite <= 1'b1;
      @(posedge clk_sys);
      spanWrite <= 1'b0;
      @(posedge clk_sys);
      #1;
      check("spanCfg", {2'b00, spanCfg}, {2'b00, v});
   endtask : writeSpan

   task automatic summarize();
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      summarize();
   end

   // ---------------------------
   // Test sequence
   // ---------------------------
   initial begin
      reset = 1'b1;
      {supplyLow, lvdsSel, twoLane, spanWrite} = 4'h0;
      spanIn = acpr_span_t'(6'h00);
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (INIT_C + 10) @(posedge clk_sys);
      #1;
      check("initDone", {7'h0, initDone}, 8'h01);
      check("spanCfg", {2'b00, spanCfg}, 8'h3F);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys);
         lvdsSel <= m[1];
         twoLane <= m[0];
         repeat (4) @(posedge clk_sys);
         #1;
         check("lvdsMode", {7'h0, lvdsMode}, {7'h0, m[1]});
         check("laneOne", {7'h0, laneOneEnable}, {7'h0, ~m[1] & m[0]});
      end
      runConv(106, 1'b1);
      check("chanCount", {6'h0, chanCount}, 8'h02);
      writeSpan(6'h05);
      runConv(51, 1'b1);
      check("chanCount", {6'h0, chanCount}, 8'h01);
      writeSpan(6'h09);
      n = convCount;
      fork
         runConv(106, 1'b1);
         begin
            repeat (30) @(posedge clk_sys);
            acpr_host_model_i.pulseTrigger(1'b1);
         end
      join
      repeat (60) @(posedge clk_sys);
      check("convCount", 8'(convCount - n), 8'h01);
      fork
         runConv(106, 1'b0);
         begin
            repeat (60) @(posedge clk_sys);
            acpr_host_model_i.setPowerDown(1'b1);
         end
      join
      check("powerDownMode", {7'h0, powerDownMode}, 8'h01);
      n = convCount;
      acpr_host_model_i.pulseTrigger(1'b1);
      repeat (150) @(posedge clk_sys);
      check("convCount", 8'(convCount - n), 8'h00);
      acpr_host_model_i.setPowerDown(1'b0);
      c = clrCount;
      acpr_host_model_i.setPowerDown(1'b1);
      repeat (RST_C + INIT_C + 10) @(posedge clk_sys);
      #1;
      check("clrCount", 8'(clrCount - c), 8'h01);
      check("spanCfg", {2'b00, spanCfg}, 8'h3F);
      check("powerDownMode", {7'h0, powerDownMode}, 8'h01);
      acpr_host_model_i.setPowerDown(1'b0);
      fork
         acpr_host_model_i.pulseTrigger(1'b0);
         begin
            repeat (50) @(posedge clk_sys);
            acpr_host_model_i.setPowerDown(1'b1);
            acpr_host_model_i.setPowerDown(1'b0);
            acpr_host_model_i.setPowerDown(1'b1);
         end
      join
      repeat (8) @(posedge clk_sys);
      #1;
      check("busy", {7'h0, busy}, 8'h00);
      acpr_host_model_i.setPowerDown(1'b0);
      repeat (RST_C + INIT_C) @(posedge clk_sys);
      #1;
      check("initDone", {7'h0, initDone}, 8'h01);
      check("napMode", {7'h0, napMode}, 8'h01);
      writeSpan(6'h32);
      @(posedge clk_sys);
      supplyLow <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1;
      check("initDone", {7'h0, initDone}, 8'h00);
      check("spanCfg", {2'b00, spanCfg}, 8'h3F);
      @(posedge clk_sys);
      supplyLow <= 1'b0;
      repeat (INIT_C + 10) @(posedge clk_sys);
      #1;
      check("initDone", {7'h0, initDone}, 8'h01);
      runConv(106, 1'b1);
      summarize();
   end
endmodule : testbench
